// *** include/spbsr_pkg.sv ***
package spbsr_pkg;
   // Bus widths
   localparam int DATA_W  = 36;
   localparam int ADDR_W  = 20;
   localparam int LANE_N  = 4;
   localparam int LANE_W  = 9;
   // Burst length in beats
   localparam int BURST_N = 2;
   // Termination range codes
   localparam logic TERM_LOW  = 1'h0;
   localparam logic TERM_HIGH = 1'h1;
   // Words per array
   localparam int ARRAY_WORDS = 1 << ADDR_W;
endpackage : spbsr_pkg

// *** include/spbsr_if.sv ***
`timescale 1ns/100ps
interface spbsr_if;
   // Controller drive
   logic                          write_port_sel_n;
   logic                          read_port_sel_n;
   logic [spbsr_pkg::ADDR_W-1:0]  addr;
   logic [spbsr_pkg::DATA_W-1:0]  wdata;
   logic [spbsr_pkg::LANE_N-1:0]  byte_lane_write_mask_n;
   logic                          clk_phase;
   logic                          termination_range_sel;
   // Memory drive
   logic [spbsr_pkg::DATA_W-1:0]  rdata;
   logic                          rdata_oe_n;
   logic                          read_valid_flag;
   logic                          echo_clock;
   modport mem
   (
      input  write_port_sel_n, read_port_sel_n, addr, wdata, byte_lane_write_mask_n,
      input  clk_phase, termination_range_sel,
      output rdata, rdata_oe_n, read_valid_flag, echo_clock
   );
   modport ctrl
   (
      output write_port_sel_n, read_port_sel_n, addr, wdata, byte_lane_write_mask_n,
      output clk_phase, termination_range_sel,
      input  rdata, rdata_oe_n, read_valid_flag, echo_clock
   );
endinterface : spbsr_if

// *** design/spbsr_mem.sv ***
`timescale 1ns/100ps
module spbsr_mem
(
   // Clock, reset, enable
   input  wire logic                          clk,
   input  wire logic                          rst,
   input  wire logic                          ce,
   // Pin side
   spbsr_if.mem                               bus,
   // Status
   output logic                               term_high_ff
);
   // twenty-bit address, two arrays
   // Two arrays: index 0 even beat, 1 odd beat
   logic [spbsr_pkg::DATA_W-1:0] arr0 [spbsr_pkg::ARRAY_WORDS];
   logic [spbsr_pkg::DATA_W-1:0] arr1 [spbsr_pkg::ARRAY_WORDS];
   logic                          wr_pend_ff;
   logic                          wr_addr_ok_ff;
   logic [spbsr_pkg::ADDR_W-1:0]  waddr_ff;
   logic                          rd_pend_ff;
   logic [spbsr_pkg::ADDR_W-1:0]  raddr_ff;
   logic                          rd_beat_ff;
   logic [spbsr_pkg::DATA_W-1:0]  rdata_ff;
   logic                          valid_ff;
   logic                          oe_n_ff;
   logic                          term_done_ff;
   logic                          pos;
   logic [spbsr_pkg::DATA_W-1:0]  nxt_word;
   logic [spbsr_pkg::DATA_W-1:0]  old_word;

   // Phase high marks the positive clock edge
   assign pos = bus.clk_phase;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         term_done_ff <= 1'h0;
         term_high_ff <= 1'h1;
      end
      else if (ce && !term_done_ff)
      begin
         term_done_ff <= 1'h1;
         term_high_ff <= (bus.termination_range_sel !== spbsr_pkg::TERM_LOW);
      end
   end

   // write start on positive phase; deselect ignores bus
   always_ff @(posedge clk)
   begin
      if (rst)
         wr_pend_ff <= 1'h0;
      else if (ce)
         wr_pend_ff <= pos && !bus.write_port_sel_n;
   end

   // write address on complementary phase when selected
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         waddr_ff      <= '0;
         wr_addr_ok_ff <= 1'h0;
      end
      else if (ce)
      begin
         if (!pos && wr_pend_ff)
            waddr_ff <= bus.addr;
         if (!pos)
            wr_addr_ok_ff <= wr_pend_ff;
         else
            wr_addr_ok_ff <= wr_addr_ok_ff && wr_pend_ff;
      end
   end

   // merge second beat lanes into odd array word
   always_comb
   begin
      old_word = arr1[waddr_ff]; // Only the odd array uses this merge
      nxt_word = old_word;
      for (int i = 0; i < spbsr_pkg::LANE_N; i++)
         if (!bus.byte_lane_write_mask_n[i])
            nxt_word[i*spbsr_pkg::LANE_W +: spbsr_pkg::LANE_W] =
               bus.wdata[i*spbsr_pkg::LANE_W +: spbsr_pkg::LANE_W];
   end

   // first beat on complementary phase, second on positive
   always_ff @(posedge clk)
   begin
      if (ce && !rst)
      begin
         if (!pos && wr_pend_ff)
            arr0[bus.addr] <= nxt_word_first(bus.addr);
         if (pos && wr_addr_ok_ff)
            arr1[waddr_ff] <= nxt_word;
      end
   end

   // Merge for first beat using fresh address
   function automatic logic [spbsr_pkg::DATA_W-1:0] nxt_word_first
   (
      input logic [spbsr_pkg::ADDR_W-1:0] a
   );
      logic [spbsr_pkg::DATA_W-1:0] w;
      w = arr0[a];
      for (int i = 0; i < spbsr_pkg::LANE_N; i++)
         if (!bus.byte_lane_write_mask_n[i])
            w[i*spbsr_pkg::LANE_W +: spbsr_pkg::LANE_W] = bus.wdata[i*spbsr_pkg::LANE_W +: spbsr_pkg::LANE_W];
      return w;
   endfunction : nxt_word_first

   // read start and address on positive phase
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rd_pend_ff <= 1'h0;
         raddr_ff   <= '0;
      end
      else if (ce && pos)
      begin
         rd_pend_ff <= !bus.read_port_sel_n;
         if (!bus.read_port_sel_n)
            raddr_ff <= bus.addr;
      end
   end

   // two beats: phase after request then next
   always_ff @(posedge clk)
   begin
      if (rst)
         rd_beat_ff <= 1'h0;
      else if (ce)
         rd_beat_ff <= !pos && rd_pend_ff;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rdata_ff <= '0;
         valid_ff <= 1'h0;
         oe_n_ff  <= 1'h1;
      end
      else if (ce)
      begin
         if (!pos && rd_pend_ff)
         begin
            rdata_ff <= arr0[raddr_ff];
            valid_ff <= 1'h1;
            oe_n_ff  <= 1'h0;
         end
         else if (rd_beat_ff)
         begin
            rdata_ff <= arr1[raddr_ff];
            valid_ff <= 1'h1;
            oe_n_ff  <= 1'h0;
         end
         else
         begin
            valid_ff <= 1'h0;
            oe_n_ff  <= 1'h1;
         end
      end
   end

   assign bus.echo_clock      = bus.clk_phase;
   assign bus.rdata           = rdata_ff;
   assign bus.read_valid_flag = valid_ff;
   assign bus.rdata_oe_n      = oe_n_ff;
endmodule : spbsr_mem

// *** design/spbsr_ctrl.sv ***
`timescale 1ns/100ps
module spbsr_ctrl
(
   // Clock, reset, enable
   input  wire logic                          clk,
   input  wire logic                          rst,
   input  wire logic                          ce,
   // User requests
   input  wire logic                          wr_req,
   input  wire logic [spbsr_pkg::ADDR_W-1:0]  wr_addr,
   input  wire logic [spbsr_pkg::DATA_W-1:0]  wr_data0,
   input  wire logic [spbsr_pkg::DATA_W-1:0]  wr_data1,
   input  wire logic [spbsr_pkg::LANE_N-1:0]  wr_mask0_n,
   input  wire logic [spbsr_pkg::LANE_N-1:0]  wr_mask1_n,
   input  wire logic                          rd_req,
   input  wire logic [spbsr_pkg::ADDR_W-1:0]  rd_addr,
   input  wire logic                          term_high,
   output logic                               req_ready,
   // Read return
   output logic [spbsr_pkg::DATA_W-1:0]       rd_data_ff,
   output logic                               rd_valid_ff,
   // Pin side
   spbsr_if.ctrl                              bus
);
   logic                          phase_ff;
   logic                          wr_ff;
   logic [spbsr_pkg::ADDR_W-1:0]  waddr_ff;
   logic [spbsr_pkg::DATA_W-1:0]  d0_ff;
   logic [spbsr_pkg::LANE_N-1:0]  m0_ff;
   logic [spbsr_pkg::DATA_W-1:0]  d1_ff;
   logic [spbsr_pkg::LANE_N-1:0]  m1_ff;
   logic                          wps_n_ff;
   logic                          rps_n_ff;
   logic [spbsr_pkg::ADDR_W-1:0]  addr_ff;
   logic [spbsr_pkg::DATA_W-1:0]  wdata_ff;
   logic [spbsr_pkg::LANE_N-1:0]  mask_ff;

   // Phase toggles; high is positive edge
   always_ff @(posedge clk)
   begin
      if (rst)
         phase_ff <= 1'h0;
      else if (ce)
         phase_ff <= !phase_ff;
   end

   // Requests taken one phase before positive edge
   assign req_ready = !phase_ff;

   // selects and read address on positive phase
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wps_n_ff <= 1'h1;
         rps_n_ff <= 1'h1;
         addr_ff  <= '0;
         wdata_ff <= '0;
         mask_ff  <= '1;
         wr_ff    <= 1'h0;
         waddr_ff <= '0;
         d0_ff    <= '0;
         m0_ff    <= '1;
         d1_ff    <= '0;
         m1_ff    <= '1;
      end
      else if (ce)
      begin
         if (!phase_ff)
         begin
            wps_n_ff <= !wr_req;
            rps_n_ff <= !rd_req;
            addr_ff  <= rd_addr;
            wr_ff    <= wr_req;
            waddr_ff <= wr_addr;
            d0_ff    <= wr_data0;
            m0_ff    <= wr_mask0_n;
            d1_ff    <= wr_data1;
            m1_ff    <= wr_mask1_n;
            wdata_ff <= d1_ff;
            mask_ff  <= wr_ff ? m1_ff : '1;
         end
         else
         begin
            addr_ff  <= waddr_ff;
            wps_n_ff <= 1'h1;
            rps_n_ff <= 1'h1;
            wdata_ff <= d0_ff;
            mask_ff  <= wr_ff ? m0_ff : '1;
         end
      end
   end

   // Capture returned read beats
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rd_data_ff  <= '0;
         rd_valid_ff <= 1'h0;
      end
      else if (ce)
      begin
         rd_valid_ff <= bus.read_valid_flag;
         rd_data_ff  <= bus.rdata;
      end
   end

   assign bus.clk_phase              = phase_ff;
   assign bus.write_port_sel_n       = wps_n_ff;
   assign bus.read_port_sel_n        = rps_n_ff;
   assign bus.addr                   = addr_ff;
   assign bus.wdata                  = wdata_ff;
   assign bus.byte_lane_write_mask_n = mask_ff;
   assign bus.termination_range_sel  = term_high;
endmodule : spbsr_ctrl

// *** testbench/spbsr_props.sv ***
`timescale 1ns/100ps
module spbsr_props
(
   // Clock and reset
   input wire logic                         clk,
   input wire logic                         rst,
   // Interface signals
   input wire logic                         write_port_sel_n,
   input wire logic                         read_port_sel_n,
   input wire logic                         clk_phase,
   input wire logic                         rdata_oe_n,
   input wire logic                         read_valid_flag,
   input wire logic                         echo_clock
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Read request and its burst
   sequence rd_start;
      !read_port_sel_n;
   endsequence
   sequence two_beats;
      read_valid_flag ##1 read_valid_flag;
   endsequence

   AST_ECHO_TOGGLES: assert property (!$past(rst) |-> echo_clock != $past(echo_clock))
      else $error("echo clock stalled");
   AST_RSEL_POS: assert property (rd_start |-> clk_phase)
      else $error("read select off positive phase");
   AST_WSEL_POS: assert property (!write_port_sel_n |-> clk_phase)
      else $error("write select off positive phase");
   AST_WSEL_ONE: assert property (!write_port_sel_n |=> write_port_sel_n)
      else $error("write select held too long");
   AST_RD_BURST: assert property (rd_start |-> ##2 two_beats)
      else $error("read burst not two beats");
   AST_VALID_OE: assert property (read_valid_flag |-> !rdata_oe_n)
      else $error("valid without driven data");
   AST_VALID_CAUSE: assert property (read_valid_flag |-> !$past(read_port_sel_n, 2) || !$past(read_port_sel_n, 3))
      else $error("valid without read select");
   AST_OE_RELEASE: assert property ($fell(read_valid_flag) |-> rdata_oe_n)
      else $error("read data not released");
   cover property (rd_start ##1 !write_port_sel_n);
endmodule : spbsr_props

// *** testbench/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
   logic                         clk        = 1'h0;
   logic                         rst        = 1'h1;
   logic                         ce         = 1'h1;
   logic                         wr_req     = 1'h0;
   logic                         rd_req     = 1'h0;
   logic                         term_high  = 1'h1;
   logic [spbsr_pkg::ADDR_W-1:0] wr_addr    = '0;
   logic [spbsr_pkg::ADDR_W-1:0] rd_addr    = '0;
   logic [spbsr_pkg::DATA_W-1:0] wr_data0   = '0;
   logic [spbsr_pkg::DATA_W-1:0] wr_data1   = '0;
   logic [spbsr_pkg::LANE_N-1:0] wr_mask0_n = '0;
   logic [spbsr_pkg::LANE_N-1:0] wr_mask1_n = '0;
   logic                         req_ready, rd_valid_ff, term_high_ff;
   logic [spbsr_pkg::DATA_W-1:0] rd_data_ff;
   logic [31:0]                  seed = 32'hde30;
   int                           n_mismatch = 0, samples_checked = 0, cycles = 0;
   logic [spbsr_pkg::ADDR_W-1:0] addrs [8];
   logic [spbsr_pkg::DATA_W-1:0] mem0 [8], mem1 [8];
   logic [spbsr_pkg::DATA_W-1:0] exp_q [$], q_user [$], q_pin [$];

   spbsr_if spbsr_if_i ();
   spbsr_mem spbsr_mem_i (.clk(clk), .rst(rst), .ce(ce), .bus(spbsr_if_i.mem), .term_high_ff(term_high_ff));
   spbsr_ctrl spbsr_ctrl_i (.clk(clk), .rst(rst), .ce(ce), .wr_req(wr_req), .wr_addr(wr_addr),
      .wr_data0(wr_data0), .wr_data1(wr_data1), .wr_mask0_n(wr_mask0_n), .wr_mask1_n(wr_mask1_n),
      .rd_req(rd_req), .rd_addr(rd_addr), .term_high(term_high), .req_ready(req_ready),
      .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff), .bus(spbsr_if_i.ctrl));
   spbsr_props spbsr_props_i (.clk(clk), .rst(rst), .write_port_sel_n(spbsr_if_i.write_port_sel_n),
      .read_port_sel_n(spbsr_if_i.read_port_sel_n), .clk_phase(spbsr_if_i.clk_phase),
      .rdata_oe_n(spbsr_if_i.rdata_oe_n), .read_valid_flag(spbsr_if_i.read_valid_flag),
      .echo_clock(spbsr_if_i.echo_clock));

   always #20 clk = ~clk;

   // Cycle ceiling and capture of read beats
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         n_mismatch++;
         end_sim();
      end
      else
      begin
         if (rd_valid_ff === 1'h1) q_user.push_back(rd_data_ff);
         if (spbsr_if_i.read_valid_flag === 1'h1) q_pin.push_back(spbsr_if_i.rdata);
      end
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   // Lanes with low mask take new data
   function automatic logic [35:0] merge(input logic [35:0] old, nw, input logic [3:0] m);
      for (int l = 0; l < 4; l++)
         if (m[l] == 1'h0) old[l*9 +: 9] = nw[l*9 +: 9];
      return old;
   endfunction : merge

   task check(input logic [35:0] seen, input logic [35:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check

   // One request slot: optional write and read
   task put(input logic w, input int wi, input logic [3:0] m0, m1, input logic r, input int ri);
      int k;
      k = 0;
      if (r)
      begin
         exp_q.push_back(mem0[ri]);
         exp_q.push_back(mem1[ri]);
      end
      @(negedge clk);
      while (req_ready !== 1'h1 && k < 8)
      begin
         @(negedge clk);
         k++;
      end
      wr_addr = addrs[wi];
      rd_addr = addrs[ri];
      wr_data0 = 36'({xs(), xs()});
      wr_data1 = 36'({xs(), xs()});
      wr_mask0_n = m0;
      wr_mask1_n = m1;
      wr_req = w;
      rd_req = r;
      if (w)
      begin
         mem0[wi] = merge(mem0[wi], wr_data0, m0);
         mem1[wi] = merge(mem1[wi], wr_data1, m1);
      end
      @(negedge clk);
      wr_req = 1'h0;
      rd_req = 1'h0;
   endtask : put

   task end_sim;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim

   initial
   begin
      for (int i = 0; i < 8; i++) addrs[i] = 20'(xs());
      addrs[0] = '0;
      addrs[7] = '1;
      repeat (6) @(negedge clk);
      rst = 1'h0;
      repeat (3) @(negedge clk);
      check(36'(term_high_ff), 36'h1);
      term_high = 1'h0;
      for (int i = 0; i < 8; i++) put(1'h1, i, 4'h0, 4'h0, 1'h0, 0);
      $display("test full writes done");
      put(1'h1, 0, 4'hf, 4'h0, 1'h1, 4);
      for (int i = 1; i < 16; i++) put(1'h1, i % 8, 4'(xs()), 4'(xs()), 1'h1, (i + 4) % 8);
      $display("test masked writes with reads done");
      for (int i = 0; i < 8; i++) put(1'h0, 0, 4'h0, 4'h0, 1'h1, i);
      repeat (10) @(negedge clk);
      while (exp_q.size() > 0)
      begin
         check(q_user.pop_front(), exp_q[0]);
         check(q_pin.pop_front(), exp_q.pop_front());
      end
      check(36'(q_pin.size()), 36'h0);
      check(36'(term_high_ff), 36'h1);
      $display("test read sweep done");
      // Second reset latches the low range
      @(negedge clk);
      rst = 1'h1;
      repeat (2) @(negedge clk);
      rst = 1'h0;
      repeat (2) @(negedge clk);
      check(36'(term_high_ff), 36'h0);
      $display("test reset range done");
      end_sim();
   end
endmodule : tb_top
